// ==== hdl/fpctl_decode.sv ====
// Turns the stored control word into datapath controls.
// Assumes the word is stable between writes.
`timescale 1ns/10ps
`default_nettype none
module fpctl_decode
   import fpctl_pkg::*;
(
   input  wire logic [63:0] word_i,
   output var  fpctl_ctrl_t ctrl_o
);
   import fpctl_pkg::*;

   always_comb begin
      ctrl_o = '0;
      ctrl_o.alternate_handling   = word_i[FPCTL_AH_BIT];
      ctrl_o.half_conv_alt        = word_i[FPCTL_ALT_HALF_BIT];
      ctrl_o.half_arith_alt       = 1'b0;
      ctrl_o.default_nan_sel      = word_i[FPCTL_DNAN_BIT];
      ctrl_o.default_nan_absmin   = 1'b0;
      ctrl_o.flush_out_sd         = word_i[FPCTL_FLUSH_BIT];
      ctrl_o.flush_in_sd          = word_i[FPCTL_FLUSH_BIT] & ~word_i[FPCTL_AH_BIT];
      ctrl_o.half_flush_denormals = word_i[FPCTL_HFLUSH_BIT];
      ctrl_o.rounding_sel         = word_i[FPCTL_RND_HI:FPCTL_RND_LO];
      if (word_i[FPCTL_AH_BIT]) begin
         ctrl_o.rounding_est = FPCTL_RND_NEAREST;
      end else begin
         ctrl_o.rounding_est = word_i[FPCTL_RND_HI:FPCTL_RND_LO];
      end
      // Stride and length feed nothing here
   end
endmodule // fpctl_decode
`default_nettype wire

// ==== hdl/fpctl_store.sv ====
// Storage of the 64-bit control word, written by software or by the legacy alias.
// Assumes the top module decodes addresses and qualifies writes.
`timescale 1ns/10ps
`default_nettype none
module fpctl_store
   import fpctl_pkg::*;
#(
   parameter bit LEGACY_VEC_EN = 1'b1,
   parameter bit HALF_FEAT     = 1'b1
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        wr_lo_i,
   input  wire logic        wr_hi_i,
   input  wire logic        wr_leg_i,
   input  wire logic [31:0] wdata_i,
   output var  logic [63:0] word_o
);
   import fpctl_pkg::*;

   typedef struct packed {
      logic [31:0] lo;
   } fpctl_store_st_t;

   fpctl_store_st_t st;
   fpctl_store_st_t next_st;
   logic [31:0]     keep_mask;

   always_comb begin
      keep_mask = FPCTL_LO_MASK;
      if (!LEGACY_VEC_EN) begin
         keep_mask[FPCTL_STRIDE_HI:FPCTL_STRIDE_LO] = 2'h0;
         keep_mask[FPCTL_LEN_HI:FPCTL_LEN_LO]       = 3'h0;
      end
      if (!HALF_FEAT) begin
         keep_mask[FPCTL_HFLUSH_BIT] = 1'b0;
      end
   end

   always_comb begin
      next_st = st;
      if (wr_lo_i) begin
         next_st.lo = wdata_i & keep_mask;
      end else if (wr_leg_i) begin
         // Alias writes touch only the shared ranges, one storage for both views
         next_st.lo = (st.lo & ~FPCTL_LEGACY_MASK) | (wdata_i & FPCTL_LEGACY_MASK & keep_mask);
      end else if (wr_hi_i) begin
         // Nothing is stored above bit 31, so a high-word write keeps the word as it is
         next_st.lo = st.lo;
      end
   end

   // Upper word holds nothing writable; writes there are accepted and dropped
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '{lo: FPCTL_RESET_LO};
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign word_o = {32'h0000_0000, st.lo};
endmodule // fpctl_store
`default_nettype wire

// ==== hdl/fpctl_top.sv ====
// Top of the floating-point control register: register port and datapath controls.
// Assumes a master that keeps to one-cycle strobes, never both at once.
`timescale 1ns/10ps
`default_nettype none
module fpctl_top
   import fpctl_pkg::*;
#(
   parameter bit LEGACY_VEC_EN = 1'b1,
   parameter bit HALF_FEAT     = 1'b1
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire fpctl_req_t  req_i,
   output var  logic [31:0] rdata_o,
   output var  fpctl_ctrl_t ctrl_o
);
   import fpctl_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      fpctl_ctrl_t ctrl;
   } fpctl_top_st_t;

   fpctl_top_st_t st;
   fpctl_top_st_t next_st;
   logic [63:0]   word;
   fpctl_ctrl_t   dec_ctrl;
   logic          wr_lo;
   logic          wr_hi;
   logic          wr_leg;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      hit = (a == base);
   endfunction

   always_comb begin
      wr_lo  = 1'b0;
      wr_hi  = 1'b0;
      wr_leg = 1'b0;
      if (req_i.wr && hit(req_i.addr, FPCTL_ADDR_CTRL_LO)) begin
         wr_lo = 1'b1;
      end else if (req_i.wr && hit(req_i.addr, FPCTL_ADDR_CTRL_HI)) begin
         wr_hi = 1'b1;
      end else if (req_i.wr && hit(req_i.addr, FPCTL_ADDR_LEGACY)) begin
         wr_leg = 1'b1;
      end
   end

   fpctl_store #(
      .LEGACY_VEC_EN (LEGACY_VEC_EN),
      .HALF_FEAT     (HALF_FEAT)
   ) u_store (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .wr_lo_i  (wr_lo),
      .wr_hi_i  (wr_hi),
      .wr_leg_i (wr_leg),
      .wdata_i  (req_i.wdata),
      .word_o   (word)
   );

   fpctl_decode u_decode (
      .word_i (word),
      .ctrl_o (dec_ctrl)
   );

   always_comb begin
      next_st      = st;
      next_st.ctrl = dec_ctrl;
      next_st.rdata = 32'h0000_0000;
      if (req_i.rd) begin
         if (hit(req_i.addr, FPCTL_ADDR_CTRL_LO)) begin
            next_st.rdata = word[31:0];
         end else if (hit(req_i.addr, FPCTL_ADDR_CTRL_HI)) begin
            next_st.rdata = word[63:32];
         end else if (hit(req_i.addr, FPCTL_ADDR_LEGACY)) begin
            next_st.rdata = word[31:0] & FPCTL_LEGACY_MASK;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign ctrl_o  = st.ctrl;
endmodule // fpctl_top
`default_nettype wire

// ==== shared/fpctl_pkg.sv ====
// Package for the floating-point control register block: field layout, offsets, carriers.
// Assumes a single core clock and a simple strobe register port.
//
// What this block does
// - The control register is one 64-bit register.
// - Bits 26 to 15 are the same storage as the legacy status/control register bits 26 to 15; here bit 15 is not stored and reads zero in both views.
// - Bits 12 to 8 are the same storage as the legacy status/control register bits 12 to 8.
// - Legacy stride and length fields either hold nonzero values or read as zero, by choice.
// - Alternative-half-format bit 0 selects IEEE half format, 1 the alternative format.
// - That bit steers only half-to-other conversions; half arithmetic always uses IEEE format.
// - Default-NaN bit 25 at 1 makes any NaN-input operation other than absolute, negate, max and min return the default NaN.
// - Absolute, negate, max and min results are not steered by the default-NaN bit.
// - Flush bit 24 at 1 with alternate handling 0 flushes single/double inputs and outputs.
// - Flush bit 24 at 1 with alternate handling 1 flushes single/double outputs only.
// - Rounding field bits 23:22 selects nearest, plus inf, minus inf, toward zero.
// - Alternate handling 1 forces nearest rounding for estimate, step and brain-float ops.
// - Legacy stride bits 21:20 and length bits 18:16 have no effect on execution.
// - Bit 19 flushes half-precision denormals when half arithmetic exists, else reads zero.
// - Fields need no defined value on warm reset; software programs them before use.
package fpctl_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0]  FPCTL_ADDR_CTRL_LO = 8'h00;
   localparam logic [7:0]  FPCTL_ADDR_CTRL_HI = 8'h04;
   localparam logic [7:0]  FPCTL_ADDR_LEGACY  = 8'h08;
   localparam int          FPCTL_WIDTH        = 64;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int FPCTL_ALT_HALF_BIT  = 26;
   localparam int FPCTL_DNAN_BIT      = 25;
   localparam int FPCTL_FLUSH_BIT     = 24;
   localparam int FPCTL_RND_HI        = 23;
   localparam int FPCTL_RND_LO        = 22;
   localparam int FPCTL_STRIDE_HI     = 21;
   localparam int FPCTL_STRIDE_LO     = 20;
   localparam int FPCTL_HFLUSH_BIT    = 19;
   localparam int FPCTL_LEN_HI        = 18;
   localparam int FPCTL_LEN_LO        = 16;
   localparam int FPCTL_AH_BIT        = 1;
   localparam int FPCTL_SHARED_HI_HI  = 26;
   localparam int FPCTL_SHARED_HI_LO  = 15;
   localparam int FPCTL_SHARED_LO_HI  = 12;
   localparam int FPCTL_SHARED_LO_LO  = 8;
   // Writable bits of the low word; trap enables are kept only as storage, bit 1 drives alternate handling
   localparam logic [31:0] FPCTL_LO_MASK      = 32'h07ff_1f02;
   localparam logic [31:0] FPCTL_LEGACY_MASK  = 32'h07ff_9f00;
   localparam logic [31:0] FPCTL_RESET_LO     = 32'h0000_0000;
   // ------------------------------------------------------------------
   // Rounding encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] FPCTL_RND_NEAREST = 2'h0;
   localparam logic [1:0] FPCTL_RND_PLUS    = 2'h1;
   localparam logic [1:0] FPCTL_RND_MINUS   = 2'h2;
   localparam logic [1:0] FPCTL_RND_ZERO    = 2'h3;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fpctl_req_t;

   // Controls delivered to the datapath
   typedef struct packed {
      logic       half_conv_alt;
      logic       half_arith_alt;
      logic       default_nan_sel;
      logic       default_nan_absmin;
      logic       flush_in_sd;
      logic       flush_out_sd;
      logic       half_flush_denormals;
      logic [1:0] rounding_sel;
      logic [1:0] rounding_est;
      logic       alternate_handling;
   } fpctl_ctrl_t;
endpackage

// ==== test/fpctl_datapath_model.sv ====
// Datapath stand-in: picks the rounding mode that an operation really uses.
// Assumes ctrl_i comes straight from the register block, with no extra staging.
`timescale 1ns/10ps
`default_nettype none
module fpctl_datapath_model
   import fpctl_pkg::*;
(
   input  wire fpctl_ctrl_t ctrl_i,
   input  wire logic        est_op_i,
   output logic [1:0]       rnd_o
);
   // Estimate and step ops follow the forced mode, all others the software field
   assign rnd_o = est_op_i ? ctrl_i.rounding_est : ctrl_i.rounding_sel;
endmodule // fpctl_datapath_model
`default_nettype wire

// ==== test/fpctl_top_properties.sv ====
// Checker on the ports of the control register top.
// Assumes binding into fpctl_top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module fpctl_top_properties
   import fpctl_pkg::*;
#(
   parameter bit HALF_FEAT = 1'b1
) (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        ce_i,
   input wire fpctl_req_t  req_i,
   input wire logic [31:0] rdata_o,
   input wire fpctl_ctrl_t ctrl_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Low-word write, then one enabled cycle for the control stage
   sequence s_wr;
      (ce_i && req_i.wr && req_i.addr == 8'h00) ##1 ce_i;
   endsequence
   property p_rd_idle;
      (ce_i && !req_i.rd) |=> rdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_rd_hi;
      (ce_i && req_i.rd && req_i.addr == 8'h04) |=> rdata_o == 32'h0;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("high word not zero");
   property p_alt;
      s_wr |=> ctrl_o.half_conv_alt == $past(req_i.wdata[26], 2);
   endproperty
   a_alt: assert property (p_alt) else $error("half format select wrong");
   property p_fixed;
      ctrl_o.half_arith_alt == 1'b0 && ctrl_o.default_nan_absmin == 1'b0;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed control set");
   property p_dnan;
      s_wr |=> ctrl_o.default_nan_sel == $past(req_i.wdata[25], 2);
   endproperty
   a_dnan: assert property (p_dnan) else $error("default nan wrong");
   property p_flush;
      s_wr |=> ctrl_o.flush_out_sd == $past(req_i.wdata[24], 2)
         && ctrl_o.flush_in_sd == ($past(req_i.wdata[24], 2) & ~$past(req_i.wdata[1], 2));
   endproperty
   a_flush: assert property (p_flush) else $error("flush controls wrong");
   property p_rnd;
      s_wr |=> ctrl_o.rounding_sel == $past(req_i.wdata[23:22], 2);
   endproperty
   a_rnd: assert property (p_rnd) else $error("rounding wrong");
   property p_est;
      ctrl_o.rounding_est == (ctrl_o.alternate_handling ? 2'h0 : ctrl_o.rounding_sel);
   endproperty
   a_est: assert property (p_est) else $error("estimate rounding wrong");
   property p_hflush;
      s_wr |=> ctrl_o.half_flush_denormals == ($past(req_i.wdata[19], 2) & HALF_FEAT);
   endproperty
   a_hflush: assert property (p_hflush) else $error("half flush wrong");
   property p_hold;
      (!req_i.wr ##1 !req_i.wr) |=> $stable(ctrl_o);
   endproperty
   a_hold: assert property (p_hold) else $error("controls moved without write");
endmodule // fpctl_top_properties
bind fpctl_top fpctl_top_properties #(.HALF_FEAT(HALF_FEAT)) u_props (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o), .ctrl_o(ctrl_o));
`default_nettype wire

// ==== test/fpctl_top_tb.sv ====
// Testbench for the control register: strobe reads and writes, control checks.
// Assumes the partner model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module fpctl_top_tb;
   import fpctl_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ce_i = 1'b1;
   fpctl_req_t  req = '0;
   logic [31:0] rdata;
   fpctl_ctrl_t ctrl;
   logic [31:0] rdata_min;
   fpctl_ctrl_t ctrl_min;
   // Stride, half flush and length bits, absent in the reduced build
   localparam logic [31:0] ABSENT = 32'h003f_0000;
   logic [1:0]  rnd_std;
   logic [1:0]  rnd_est;
   logic [31:0] d;
   int          mismatches = 0;
   int          compares = 0;
   always #25 mclk_i = ~mclk_i;
   fpctl_top #(.LEGACY_VEC_EN(1'b1), .HALF_FEAT(1'b1)) dut (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req), .rdata_o(rdata), .ctrl_o(ctrl));
   fpctl_top #(.LEGACY_VEC_EN(1'b0), .HALF_FEAT(1'b0)) dut_min (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req), .rdata_o(rdata_min), .ctrl_o(ctrl_min));
   fpctl_datapath_model u_std (.ctrl_i(ctrl), .est_op_i(1'b0), .rnd_o(rnd_std));
   fpctl_datapath_model u_est (.ctrl_i(ctrl), .est_op_i(1'b1), .rnd_o(rnd_est));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      req.wr <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      req.rd <= 1'b0;
      @(negedge mclk_i);
      chk(rdata, exp, what);
      chk(rdata_min, exp & ~ABSENT, {what, " min"});
      @(posedge mclk_i);
   endtask
   task automatic complete_run();
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog: the whole sequence needs far fewer cycles
   initial begin
      repeat (3000) @(posedge mclk_i);
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      rd(8'h00, 32'h0, "reset word");
      for (int i = 0; i < 8; i++) begin
         // Stride, length and unwritable bits all set to show they change nothing
         d = {5'h1f, i[2], i[1], i[0], i[1:0], 2'h3, i[0], 3'h7, 14'h3fff, i[2], 1'b1};
         wr(8'h00, d);
         @(negedge mclk_i);
         chk(32'({ctrl.half_conv_alt, ctrl.half_arith_alt}), 32'({i[2], 1'b0}), "half");
         chk(32'({ctrl.default_nan_sel, ctrl.default_nan_absmin}), 32'({i[1], 1'b0}), "nan");
         chk(32'({ctrl.flush_in_sd, ctrl.flush_out_sd}), 32'({i[0] & ~i[2], i[0]}), "flush");
         chk(32'({rnd_std, ctrl.rounding_sel}), 32'({i[1:0], i[1:0]}), "round");
         chk(32'(rnd_est), 32'(i[2] ? 2'h0 : i[1:0]), "estimate");
         chk(32'(ctrl.half_flush_denormals), 32'(i[0]), "half flush");
         chk(32'(ctrl_min.half_flush_denormals), 32'h0, "half flush absent");
         chk(32'(ctrl.alternate_handling), 32'(i[2]), "alt handling");
         @(posedge mclk_i);
         rd(8'h00, d & FPCTL_LO_MASK, "word");
      end
      $display("test fields done");
      wr(8'h04, 32'hffff_ffff);
      rd(8'h04, 32'h0, "high word");
      wr(8'h0c, 32'h0);
      rd(8'h0c, 32'h0, "unmapped");
      rd(8'h00, d & FPCTL_LO_MASK, "kept");
      $display("test map done");
      wr(8'h08, 32'hffff_ffff);
      rd(8'h08, FPCTL_LEGACY_MASK & FPCTL_LO_MASK, "alias");
      // Alias write leaves bits outside the shared ranges as they were
      d = (d & FPCTL_LO_MASK & ~FPCTL_LEGACY_MASK) | (FPCTL_LEGACY_MASK & FPCTL_LO_MASK);
      rd(8'h00, d, "shared");
      $display("test alias done");
      ce_i <= 1'b0;
      wr(8'h00, 32'h0);
      ce_i <= 1'b1;
      rd(8'h00, d, "frozen");
      $display("test enable done");
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(negedge mclk_i);
      chk(32'(ctrl), 32'h0, "reset controls");
      @(posedge mclk_i);
      rd(8'h00, 32'h0, "reset again");
      $display("test reset done");
      complete_run();
   end
endmodule // fpctl_top_tb
`default_nettype wire
